// file: hw/ssslv_pkg.sv
package ssslv_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] OFS_RX_STATUS = 8'h00;
	localparam logic [7:0] OFS_TX_HOLD = 8'h04;
	localparam logic [7:0] OFS_TX_STATUS = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0C;
	localparam logic [7:0] OFS_DIV_HIGH = 8'h10;
	localparam logic [7:0] OFS_DIV_LOW = 8'h14;
	localparam logic [7:0] OFS_RX_HOLD = 8'h18;
	localparam logic [7:0] OFS_FLAGS = 8'h1C;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 4;
	// receive status/control bits
	localparam int RS_PORT_ON = 7;
	localparam int RS_RX9 = 6;
	localparam int RS_SINGLE = 5;
	localparam int RS_CONT = 4;
	localparam int RS_ADDR_EN = 3;
	localparam int RS_FRAME_ERR = 2;
	localparam int RS_OVERRUN = 1;
	localparam int RS_RX_NINTH = 0;
	// transmit status/control bits
	localparam int TS_CLK_SRC = 7;
	localparam int TS_TX9 = 6;
	localparam int TS_TX_EN = 5;
	localparam int TS_SYNC = 4;
	localparam int TS_BREAK = 3;
	localparam int TS_HIGH_RATE = 2;
	localparam int TS_SHIFT_EMPTY = 1;
	localparam int TS_TX_NINTH = 0;
	// baud control bits
	localparam int BC_RX_IDLE = 6;
	localparam int BC_CLK_POL = 4;
	localparam int BC_DIV16 = 3;
	localparam int BC_WAKE_EN = 1;
	localparam int BC_AUTO_BAUD = 0;
	// flag/enable register bits
	localparam int FL_TX_EMPTY = 0;
	localparam int FL_RX_FULL = 1;
	localparam int FL_TX_IE = 4;
	localparam int FL_RX_IE = 5;
	// reset values and bit counts
	localparam logic [7:0] RST_TX_STATUS = 8'h02;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [3:0] BITS_SHORT = 4'h8;
	localparam logic [3:0] BITS_LONG = 4'h9;
endpackage

// file: hw/ssslv_sync.sv
`timescale 1ns/100ps
module ssslv_sync #(
	parameter int WIDTH = 1
) (
	// clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	// level in and synchronised level out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= '0;
			q <= '0;
		end else if (en) begin
			stage <= d;
			q <= stage;
		end
	end
endmodule

// file: hw/ssslv_top.sv
`timescale 1ns/100ps
module ssslv_top #(
	parameter int ADDR_W = 8
) (
	// clock, enable, reset
	input wire logic mclk,
	input wire logic ce,
	input wire logic arst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// shift clock pin, input only in slave mode
	input wire logic shift_clock_pin,
	// two-way data pin
	input wire logic dt_in,
	output logic dt_out,
	output logic dt_oe_n,
	// power state and requests toward the core
	input wire logic low_power,
	output logic tx_irq,
	output logic rx_irq,
	output logic wake
);
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic dp_wr;
		logic [2:0] dp_idx;
		logic dp_map;
		logic serial_port_on;
		logic nine_bit_rx_select;
		logic single_rx_enable;
		logic continuous_rx_enable;
		logic addr_en;
		logic overrun;
		logic rx_ninth;
		logic clock_source_select;
		logic nine_bit_tx_select;
		logic transmit_enable;
		logic sync_mode;
		logic send_break;
		logic high_rate;
		logic tx_ninth_bit;
		logic clk_pol;
		logic div16;
		logic wake_en;
		logic auto_baud;
		logic [7:0] div_high;
		logic [7:0] div_low;
		logic [7:0] transmit_holding;
		logic tx_buffer_empty_flag;
		logic [8:0] transmit_shifter;
		logic tx_busy;
		logic [3:0] tx_cnt;
		logic [8:0] receive_shifter;
		logic [3:0] rx_cnt;
		logic [7:0] receive_holding;
		logic rx_buffer_full_flag;
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic ck_prev;
		logic dt_out;
		logic dt_oe_n;
		logic tx_irq;
		logic rx_irq;
		logic wake;
	} ssslv_state_s;

	logic rst_n;
	logic ck_s;
	logic dt_s;
	ssslv_state_s st;
	ssslv_state_s next_st;

	// reset release through two flops
	ssslv_sync #(.WIDTH(1)) u_rst_sync (
		.clk(mclk),
		.rst_n(arst_n),
		.en(1'b1),
		.d(1'b1),
		.q(rst_n)
	);

	ssslv_sync #(.WIDTH(2)) u_pin_sync (
		.clk(mclk),
		.rst_n(rst_n),
		.en(ce),
		.d({shift_clock_pin, dt_in}),
		.q({ck_s, dt_s})
	);

	function automatic logic [7:0] rd_value(input ssslv_state_s s, input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case ({idx, 2'b00})
			ssslv_pkg::OFS_RX_STATUS: begin
				v[ssslv_pkg::RS_PORT_ON] = s.serial_port_on;
				v[ssslv_pkg::RS_RX9] = s.nine_bit_rx_select;
				v[ssslv_pkg::RS_SINGLE] = s.single_rx_enable;
				v[ssslv_pkg::RS_CONT] = s.continuous_rx_enable;
				v[ssslv_pkg::RS_ADDR_EN] = s.addr_en;
				v[ssslv_pkg::RS_OVERRUN] = s.overrun;
				v[ssslv_pkg::RS_RX_NINTH] = s.rx_ninth;
			end
			ssslv_pkg::OFS_TX_HOLD: v = s.transmit_holding;
			ssslv_pkg::OFS_TX_STATUS: begin
				v[ssslv_pkg::TS_CLK_SRC] = s.clock_source_select;
				v[ssslv_pkg::TS_TX9] = s.nine_bit_tx_select;
				v[ssslv_pkg::TS_TX_EN] = s.transmit_enable;
				v[ssslv_pkg::TS_SYNC] = s.sync_mode;
				v[ssslv_pkg::TS_BREAK] = s.send_break;
				v[ssslv_pkg::TS_HIGH_RATE] = s.high_rate;
				v[ssslv_pkg::TS_SHIFT_EMPTY] = ~s.tx_busy;
				v[ssslv_pkg::TS_TX_NINTH] = s.tx_ninth_bit;
			end
			ssslv_pkg::OFS_BAUD: begin
				v[ssslv_pkg::BC_RX_IDLE] = (s.rx_cnt == 4'h0);
				v[ssslv_pkg::BC_CLK_POL] = s.clk_pol;
				v[ssslv_pkg::BC_DIV16] = s.div16;
				v[ssslv_pkg::BC_WAKE_EN] = s.wake_en;
				v[ssslv_pkg::BC_AUTO_BAUD] = s.auto_baud;
			end
			ssslv_pkg::OFS_DIV_HIGH: v = s.div_high;
			ssslv_pkg::OFS_DIV_LOW: v = s.div_low;
			ssslv_pkg::OFS_RX_HOLD: v = s.receive_holding;
			ssslv_pkg::OFS_FLAGS: begin
				v[ssslv_pkg::FL_TX_EMPTY] = s.tx_buffer_empty_flag;
				v[ssslv_pkg::FL_RX_FULL] = s.rx_buffer_full_flag;
				v[ssslv_pkg::FL_TX_IE] = s.tx_irq_enable;
				v[ssslv_pkg::FL_RX_IE] = s.rx_irq_enable;
			end
		endcase
		return v;
	endfunction

	always_comb begin
		logic slave_on;
		logic tx_on;
		logic rx_on;
		logic ck_lvl;
		logic ck_rise;
		logic ck_fall;
		logic [3:0] nbits;
		logic [8:0] rsr_new;
		logic [7:0] w;
		logic addr_ok;
		slave_on = 1'b0;
		tx_on = 1'b0;
		rx_on = 1'b0;
		ck_lvl = 1'b0;
		ck_rise = 1'b0;
		ck_fall = 1'b0;
		nbits = ssslv_pkg::BITS_SHORT;
		rsr_new = 9'h000;
		w = hwdata[7:0];
		addr_ok = 1'b0;
		next_st = st;

		// write data phase
		if (st.dp_wr && st.dp_map) begin
			unique case ({st.dp_idx, 2'b00})
				ssslv_pkg::OFS_RX_STATUS: begin
					next_st.serial_port_on = w[ssslv_pkg::RS_PORT_ON];
					next_st.nine_bit_rx_select = w[ssslv_pkg::RS_RX9];
					next_st.single_rx_enable = w[ssslv_pkg::RS_SINGLE];
					next_st.continuous_rx_enable = w[ssslv_pkg::RS_CONT];
					next_st.addr_en = w[ssslv_pkg::RS_ADDR_EN];
					if (!w[ssslv_pkg::RS_CONT]) begin
						next_st.overrun = 1'b0;
					end
				end
				ssslv_pkg::OFS_TX_HOLD: begin
					next_st.transmit_holding = w;
					next_st.tx_buffer_empty_flag = 1'b0;
				end
				ssslv_pkg::OFS_TX_STATUS: begin
					next_st.clock_source_select = w[ssslv_pkg::TS_CLK_SRC];
					next_st.nine_bit_tx_select = w[ssslv_pkg::TS_TX9];
					next_st.transmit_enable = w[ssslv_pkg::TS_TX_EN];
					next_st.sync_mode = w[ssslv_pkg::TS_SYNC];
					next_st.send_break = w[ssslv_pkg::TS_BREAK];
					next_st.high_rate = w[ssslv_pkg::TS_HIGH_RATE];
					next_st.tx_ninth_bit = w[ssslv_pkg::TS_TX_NINTH];
				end
				ssslv_pkg::OFS_BAUD: begin
					next_st.clk_pol = w[ssslv_pkg::BC_CLK_POL];
					next_st.div16 = w[ssslv_pkg::BC_DIV16];
					next_st.wake_en = w[ssslv_pkg::BC_WAKE_EN];
					next_st.auto_baud = w[ssslv_pkg::BC_AUTO_BAUD];
				end
				ssslv_pkg::OFS_DIV_HIGH: next_st.div_high = w;
				ssslv_pkg::OFS_DIV_LOW: next_st.div_low = w;
				ssslv_pkg::OFS_FLAGS: begin
					next_st.tx_irq_enable = w[ssslv_pkg::FL_TX_IE];
					next_st.rx_irq_enable = w[ssslv_pkg::FL_RX_IE];
				end
				default: begin
				end
			endcase
		end

		// address phase, read sees a write still in its data phase
		next_st.dp_wr = 1'b0;
		if (hready) begin
			addr_ok = (haddr[ADDR_W-1:ssslv_pkg::IDX_MSB+1] == '0);
			next_st.dp_idx = haddr[ssslv_pkg::IDX_MSB:ssslv_pkg::IDX_LSB];
			next_st.dp_map = addr_ok;
			if (hsel && htrans[1]) begin
				next_st.dp_wr = hwrite;
				if (!hwrite) begin
					next_st.hrdata = 32'h0000_0000;
					if (addr_ok) begin
						next_st.hrdata[7:0] = rd_value(next_st, haddr[ssslv_pkg::IDX_MSB:ssslv_pkg::IDX_LSB]);
					end
					if (addr_ok && ({haddr[ssslv_pkg::IDX_MSB:ssslv_pkg::IDX_LSB], 2'b00} == ssslv_pkg::OFS_RX_HOLD)) begin
						next_st.rx_buffer_full_flag = 1'b0;
					end
				end
			end
		end

		// slave only with external clock source
		slave_on = next_st.serial_port_on && next_st.sync_mode && !next_st.clock_source_select;
		// single receive enable plays no part
		rx_on = slave_on && next_st.continuous_rx_enable && !next_st.overrun;
		tx_on = slave_on && next_st.transmit_enable && !next_st.continuous_rx_enable;

		ck_lvl = ck_s ^ st.clk_pol;
		next_st.ck_prev = ck_lvl;
		ck_rise = ck_lvl && !st.ck_prev;
		ck_fall = !ck_lvl && st.ck_prev;

		// data changes on rising, sampled on falling edge
		if (!tx_on) begin
			next_st.tx_busy = 1'b0;
			next_st.tx_cnt = 4'h0;
		end else if (st.tx_busy) begin
			nbits = st.nine_bit_tx_select ? ssslv_pkg::BITS_LONG : ssslv_pkg::BITS_SHORT;
			if (ck_rise && st.tx_cnt != 4'h0) begin
				next_st.transmit_shifter = {1'b0, st.transmit_shifter[8:1]};
				next_st.dt_out = st.transmit_shifter[1];
			end
			if (ck_fall) begin
				next_st.tx_cnt = st.tx_cnt + 4'h1;
				// shifter frees, held word loads next cycle
				if (st.tx_cnt + 4'h1 == nbits) begin
					next_st.tx_busy = 1'b0;
				end
			end
		end else if (!next_st.tx_buffer_empty_flag) begin
			// empty shifter takes the word at once
			next_st.transmit_shifter = {next_st.tx_ninth_bit, next_st.transmit_holding};
			next_st.dt_out = next_st.transmit_holding[0];
			next_st.tx_busy = 1'b1;
			next_st.tx_cnt = 4'h0;
			// flag sets on every move into shifter
			next_st.tx_buffer_empty_flag = 1'b1;
		end
		// busy shifter leaves the second word and flag alone
		next_st.dt_oe_n = !tx_on;

		// receive runs regardless of low power
		if (!rx_on) begin
			next_st.rx_cnt = 4'h0;
		end else if (ck_fall) begin
			nbits = st.nine_bit_rx_select ? ssslv_pkg::BITS_LONG : ssslv_pkg::BITS_SHORT;
			rsr_new = {dt_s, st.receive_shifter[8:1]};
			next_st.receive_shifter = rsr_new;
			next_st.rx_cnt = st.rx_cnt + 4'h1;
			if (st.rx_cnt + 4'h1 == nbits) begin
				next_st.rx_cnt = 4'h0;
				if (next_st.rx_buffer_full_flag) begin
					next_st.overrun = 1'b1;
				end else begin
					next_st.receive_holding = st.nine_bit_rx_select ? rsr_new[7:0] : rsr_new[8:1];
					next_st.rx_ninth = st.nine_bit_rx_select ? rsr_new[8] : 1'b0;
					// full flag set, set beats read clear
					next_st.rx_buffer_full_flag = 1'b1;
				end
			end
		end

		next_st.tx_irq = next_st.tx_buffer_empty_flag && next_st.tx_irq_enable;
		next_st.rx_irq = next_st.rx_buffer_full_flag && next_st.rx_irq_enable;
		// either request, transmit or receive, wakes from low power
		next_st.wake = low_power && (next_st.tx_irq || next_st.rx_irq);
		next_st.hreadyout = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.hreadyout <= 1'b1;
			st.tx_buffer_empty_flag <= 1'b1;
			st.dt_oe_n <= 1'b1;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign hreadyout = st.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = st.hrdata;
	assign dt_out = st.dt_out;
	assign dt_oe_n = st.dt_oe_n;
	assign tx_irq = st.tx_irq;
	assign rx_irq = st.rx_irq;
	assign wake = st.wake;
endmodule

// file: dv/ssslv_props.sv
`timescale 1ns/100ps
module ssslv_props #(
	parameter int ADDR_W = 8
) (
	// clock, reset, bus
	input wire logic mclk, arst_n, hsel, hready, hreadyout, hresp,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [31:0] hrdata,
	// power and requests
	input wire logic low_power, tx_irq, rx_irq, wake
);
	logic [3:0] tx_hist;
	logic [3:0] rx_hist;
	wire take = hsel && hready && htrans[1];
	// recent accesses that may lower a request
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_hist <= 4'h0;
			rx_hist <= 4'h0;
		end else begin
			tx_hist <= {tx_hist[2:0], take && (haddr == 8'h04 || haddr == 8'h1C)};
			rx_hist <= {rx_hist[2:0], take && (haddr == 8'h18 || haddr == 8'h1C)};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// wake follows the registered request together with the power state of the cycle before
	sequence sleep_tx;
		$past(low_power) && tx_irq;
	endsequence
	sequence sleep_rx;
		$past(low_power) && rx_irq;
	endsequence
	a_ready_high: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_rdata_byte: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits set");
	a_wake_tx: assert property (sleep_tx |-> wake) else $error("no wake on tx empty");
	a_wake_rx: assert property (sleep_rx |-> wake) else $error("no wake on rx full");
	a_wake_cause: assert property (wake |-> $past(low_power) && (tx_irq || rx_irq))
		else $error("wake without cause");
	a_tx_lower: assert property ($fell(tx_irq) |-> |tx_hist) else $error("tx request dropped");
	a_rx_lower: assert property ($fell(rx_irq) |-> |rx_hist) else $error("rx request dropped");
endmodule
bind ssslv_top ssslv_props #(.ADDR_W(ADDR_W)) props (
	.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.haddr(haddr), .htrans(htrans), .hrdata(hrdata), .low_power(low_power), .tx_irq(tx_irq),
	.rx_irq(rx_irq), .wake(wake)
);

// file: dv/ssslv_link_model.sv
`timescale 1ns/100ps
module ssslv_link_model (
	// link pins
	output logic sck,
	output logic line,
	input wire logic dt_out,
	input wire logic dt_oe_n
);
	logic m_en;
	logic m_bit;
	initial begin
		sck = 1'b0;
		m_en = 1'b0;
		m_bit = 1'b0;
	end
	assign line = !dt_oe_n ? dt_out : (m_en ? m_bit : ~m_bit);
	task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = 9'h000;
		#13 m_en = 1'b1;
		for (int i = 0; i < n; i++) begin
			#160 sck = 1'b1;
			m_bit = tx[i];
			#160 sck = 1'b0;
			rx[i] = line;
		end
		#160 m_en = 1'b0;
	endtask
endmodule

// file: dv/test_ssslv_top.sv
`timescale 1ns/100ps
module test_ssslv_top;
	logic mclk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, low_power = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [8:0] got;
	wire hready, hreadyout, hresp, sck, line, dt_out, dt_oe_n, tx_irq, rx_irq, wake;
	wire [31:0] hrdata;
	wire [2:0] evt = {rx_irq, tx_irq, hreadyout};
	int failures = 0;
	int samples_checked = 0;
	assign hready = hreadyout;
	always #20 mclk = ~mclk;
	ssslv_top dut (
		.mclk(mclk), .ce(1'b1), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.shift_clock_pin(sck), .dt_in(line), .dt_out(dt_out), .dt_oe_n(dt_oe_n), .low_power(low_power),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .wake(wake)
	);
	ssslv_link_model link (.sck(sck), .line(line), .dt_out(dt_out), .dt_oe_n(dt_oe_n));
	task automatic close_out;
		$display("checked %0d, failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// sampled mid-cycle so that edge updates have landed
	task automatic await(input int sel);
		int n;
		n = 0;
		@(negedge mclk);
		while (evt[sel] !== 1'b1) begin
			n++;
			if (n > 500) begin
				failures++;
				close_out;
			end
			@(negedge mclk);
		end
	endtask
	// holds the current phase until hready is seen high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge mclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 500) begin
				failures++;
				close_out;
			end
			@(posedge mclk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(v, e);
	endtask
	task automatic t_regs;
		rdchk(8'h08, 32'h02);
		rdchk(8'h1C, 32'h01);
		wr(8'h14, 32'h123456A5);
		rdchk(8'h14, 32'hA5);
		wr(8'h20, 32'hFF);
		rdchk(8'h20, 32'h00);
		$display("test regs done");
	endtask
	task automatic t_tx;
		wr(8'h00, 32'h80);
		wr(8'h08, 32'h30);
		wr(8'h1C, 32'h10);
		low_power <= 1'b1;
		wr(8'h04, 32'h3C);
		rdchk(8'h1C, 32'h11);
		rdchk(8'h08, 32'h30);
		wr(8'h04, 32'hA5);
		rdchk(8'h1C, 32'h10);
		chk(wake, 1'b0);
		link.xfer(9'h000, 8, got);
		chk(got, 32'h03C);
		await(1);
		@(negedge mclk);
		chk(wake, 1'b1);
		rdchk(8'h1C, 32'h11);
		link.xfer(9'h000, 8, got);
		chk(got, 32'h0A5);
		low_power <= 1'b0;
		rdchk(8'h08, 32'h32);
		wr(8'h08, 32'h71);
		wr(8'h04, 32'h5A);
		link.xfer(9'h000, 9, got);
		chk(got, 32'h15A);
		$display("test tx done");
	endtask
	task automatic t_rx;
		wr(8'h08, 32'h10);
		wr(8'h1C, 32'h20);
		wr(8'h00, 32'hA0);
		link.xfer(9'h0C3, 8, got);
		rdchk(8'h1C, 32'h21);
		wr(8'h00, 32'hB0);
		low_power <= 1'b1;
		link.xfer(9'h0C3, 8, got);
		await(2);
		@(negedge mclk);
		chk(wake, 1'b1);
		low_power <= 1'b0;
		rdchk(8'h1C, 32'h23);
		rdchk(8'h00, 32'hB0);
		rdchk(8'h18, 32'hC3);
		rdchk(8'h1C, 32'h21);
		link.xfer(9'h011, 8, got);
		link.xfer(9'h022, 8, got);
		rdchk(8'h00, 32'hB2);
		rdchk(8'h18, 32'h11);
		wr(8'h00, 32'h80);
		rdchk(8'h00, 32'h80);
		wr(8'h00, 32'hD0);
		link.xfer(9'h1E7, 9, got);
		await(2);
		rdchk(8'h00, 32'hD1);
		rdchk(8'h18, 32'hE7);
		$display("test rx done");
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_regs();
		t_tx();
		t_rx();
		close_out();
	end
endmodule
